// File: hdl/irq_defines.svh
`ifndef IRQ_DEFINES_SVH
`define IRQ_DEFINES_SVH

// register offsets
`define IRQ_OFS_ENABLE_MAIN 8'ha8
`define IRQ_OFS_PRIORITY_MAIN 8'hb8
`define IRQ_OFS_ENABLE_EXT 8'he6
`define IRQ_OFS_PRIORITY_EXT 8'hf6
`define IRQ_OFS_PENDING_LO 8'ha7
`define IRQ_OFS_PENDING_HI 8'haf
`define IRQ_OFS_STATUS 8'hc9

// field positions
`define IRQ_GLOBAL_EN_BIT 7
`define IRQ_MAIN_SRC_COUNT 7
`define IRQ_PEND_LO_COUNT 8
`define IRQ_STAT_INSVC_LO_BIT 0
`define IRQ_STAT_INSVC_HI_BIT 1
`define IRQ_STAT_CALLING_BIT 2
`define IRQ_STAT_REQ_BIT 3

// reset values and implemented-bit masks
`define IRQ_RST_ENABLE 8'h00
`define IRQ_RST_PRIORITY 8'h00
`define IRQ_RST_PENDING 12'h000
`define IRQ_MASK_PRIORITY_MAIN 8'h7f
`define IRQ_MASK_EXT 8'hb9

// sources whose flag is cleared when the core vectors
`define IRQ_AUTO_CLEAR 12'h00f

// vector layout and timing
`define IRQ_VECTOR_BASE 16'h0003
`define IRQ_CALL_CYCLES 3'h4

`endif

// File: hdl/irq_pkg.sv
package irq_pkg;

	typedef logic [11:0] src_vec_t;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wrData;
		logic wrStrobe;
		logic rdStrobe;
	} bus_req_t;

	typedef struct packed {
		logic instrDone;
		logic retiDone;
	} core_status_t;

	typedef struct packed {
		logic request;
		logic callStart;
		logic calling;
		logic [15:0] vector;
		logic [3:0] source;
	} call_out_t;

	typedef enum logic [1:0] {
		CALL_IDLE = 2'b00,
		CALL_RUN = 2'b01
	} call_state_t;

endpackage

// File: hdl/irq_arbiter.sv
`timescale 1ns/10ps

module irq_arbiter (
	// source state
	input wire irq_pkg::src_vec_t pending,
	input wire irq_pkg::src_vec_t enable,
	input wire irq_pkg::src_vec_t highPrio,
	input wire logic globalEn,
	// service state
	input wire logic inSvcLow,
	input wire logic inSvcHigh,
	// winner
	output logic hit,
	output logic [3:0] hitSrc,
	output logic hitHigh
);

	// lowest index wins: fixed order among equals
	function automatic logic [3:0] first_set(input irq_pkg::src_vec_t v);
		logic [3:0] idx;
		idx = 4'h0;
		for (int i = 11; i >= 0; i--) begin
			if (v[i]) begin
				idx = 4'(i);
			end
		end
		return idx;
	endfunction

	irq_pkg::src_vec_t eligible;
	irq_pkg::src_vec_t highCand;
	irq_pkg::src_vec_t lowCand;

	assign eligible = pending & enable & {12{globalEn}};
	assign highCand = eligible & highPrio;
	assign lowCand = eligible & ~highPrio;

	always_comb begin
		hit = 1'b0;
		hitSrc = 4'h0;
		hitHigh = 1'b0;
		// a high-level routine is never preempted
		if (!inSvcHigh) begin
			if (highCand != 12'h000) begin
				hit = 1'b1;
				hitSrc = first_set(highCand);
				hitHigh = 1'b1;
			end else if (!inSvcLow && lowCand != 12'h000) begin
				hit = 1'b1;
				hitSrc = first_set(lowCand);
			end
		end
	end

endmodule

// File: hdl/two_level_interrupt_handler.sv
`timescale 1ns/10ps
`include "irq_defines.svh"

// Behaviour
// - twelve sources, two priority levels each
// - source condition sets its pending flag
// - flag sets even when source disabled
// - enabled pending source forces long call
// - return instruction resumes interrupted program flow
// - disabled source never raises a request
// - per-source enable in main/extended register
// - individual enables need global enable set
// - global enable clear blocks every source
// - blocked interrupts stay pending until enabled
// - some flags cleared automatically at vectoring
// - flag still set after return re-requests
// - enable registers at 0xa8 and 0xe6
// - priority registers at 0xb8 and 0xf6
// - high preempts low, high never preempted
// - higher level first, then fixed order
// - decode every clock, five-cycle minimum response
// - software-set flag vectors like hardware flag
module two_level_interrupt_handler (
	// clock and reset
	input wire logic clock,
	input wire logic reset_n,
	// register port
	input wire irq_pkg::bus_req_t busReq,
	output logic [7:0] rdData,
	// source condition pulses
	input wire irq_pkg::src_vec_t srcEvent,
	// core handshake
	input wire irq_pkg::core_status_t coreStatus,
	output irq_pkg::call_out_t callOut
);

	// extended register bit of sources 7..11
	function automatic int ext_bit(input int i);
		case (i)
			7: return 0;
			8: return 3;
			9: return 4;
			10: return 5;
			default: return 7;
		endcase
	endfunction

	// vector slot of each source, which spaces the vectors; slots 8, 9 and 13 stay unused
	function automatic logic [3:0] src_order(input logic [3:0] s);
		case (s)
			4'h8: return 4'ha;
			4'h9: return 4'hb;
			4'ha: return 4'hc;
			4'hb: return 4'he;
			default: return s;
		endcase
	endfunction

	function automatic logic bus_hit(input irq_pkg::bus_req_t r, input logic [7:0] ofs);
		return r.wrStrobe && r.addr == ofs;
	endfunction

	logic [7:0] ieMain_r;
	logic [7:0] ipMain_r;
	logic [7:0] ieExt_r;
	logic [7:0] ipExt_r;
	irq_pkg::src_vec_t pending_r;
	irq_pkg::src_vec_t pending_nxt;
	irq_pkg::src_vec_t srcEnable;
	irq_pkg::src_vec_t srcHigh;
	logic inSvcLow_r;
	logic inSvcHigh_r;
	logic reqValid_r;
	logic [3:0] reqSrc_r;
	logic reqHigh_r;
	logic arbHit;
	logic [3:0] arbSrc;
	logic arbHigh;
	irq_pkg::call_state_t state_r;
	logic [2:0] callCnt_r;
	logic callStart_r;
	logic [15:0] vector_r;
	logic [3:0] source_r;
	logic [7:0] rdData_r;
	logic takeCall;
	logic callLast;

	generate
		for (genvar g = 0; g < 12; g++) begin : gSrc
			if (g < `IRQ_MAIN_SRC_COUNT) begin : gMain
				assign srcEnable[g] = ieMain_r[g];
				assign srcHigh[g] = ipMain_r[g];
			end else begin : gExt
				assign srcEnable[g] = ieExt_r[ext_bit(g)];
				assign srcHigh[g] = ipExt_r[ext_bit(g)];
			end
		end
	endgenerate

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			ieMain_r <= `IRQ_RST_ENABLE;
			ieExt_r <= `IRQ_RST_ENABLE;
		end else begin
			if (bus_hit(busReq, `IRQ_OFS_ENABLE_MAIN)) begin
				ieMain_r <= busReq.wrData;
			end
			if (bus_hit(busReq, `IRQ_OFS_ENABLE_EXT)) begin
				ieExt_r <= busReq.wrData & `IRQ_MASK_EXT;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			ipMain_r <= `IRQ_RST_PRIORITY;
			ipExt_r <= `IRQ_RST_PRIORITY;
		end else begin
			if (bus_hit(busReq, `IRQ_OFS_PRIORITY_MAIN)) begin
				ipMain_r <= busReq.wrData & `IRQ_MASK_PRIORITY_MAIN;
			end
			if (bus_hit(busReq, `IRQ_OFS_PRIORITY_EXT)) begin
				ipExt_r <= busReq.wrData & `IRQ_MASK_EXT;
			end
		end
	end

	// pending flags: software write, then vector clear, then event set
	always_comb begin
		pending_nxt = pending_r;
		if (bus_hit(busReq, `IRQ_OFS_PENDING_LO)) begin
			pending_nxt[7:0] = busReq.wrData;
		end
		if (bus_hit(busReq, `IRQ_OFS_PENDING_HI)) begin
			pending_nxt[11:8] = busReq.wrData[3:0];
		end
		// auto clear on vectoring
		// a macro literal cannot be bit-selected, so the table is masked instead
		if (takeCall && (`IRQ_AUTO_CLEAR & (12'h001 << reqSrc_r)) != 12'h000) begin
			pending_nxt[reqSrc_r] = 1'b0;
		end
		pending_nxt = pending_nxt | srcEvent;
	end

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			pending_r <= `IRQ_RST_PENDING;
		end else begin
			pending_r <= pending_nxt;
		end
	end

	irq_arbiter u_irq_arbiter (
		.pending(pending_r),
		.enable(srcEnable),
		.highPrio(srcHigh),
		.globalEn(ieMain_r[`IRQ_GLOBAL_EN_BIT]),
		.inSvcLow(inSvcLow_r),
		.inSvcHigh(inSvcHigh_r),
		.hit(arbHit),
		.hitSrc(arbSrc),
		.hitHigh(arbHigh)
	);

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			reqValid_r <= 1'b0;
			reqSrc_r <= 4'h0;
			reqHigh_r <= 1'b0;
		end else begin
			// a call in progress already owns the core
			reqValid_r <= arbHit && !takeCall && state_r == irq_pkg::CALL_IDLE;
			reqSrc_r <= arbSrc;
			reqHigh_r <= arbHigh;
		end
	end

	assign takeCall = state_r == irq_pkg::CALL_IDLE && reqValid_r && coreStatus.instrDone;
	assign callLast = callCnt_r == `IRQ_CALL_CYCLES - 3'h1;

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			state_r <= irq_pkg::CALL_IDLE;
			callCnt_r <= 3'h0;
		end else begin
			case (state_r)
				irq_pkg::CALL_IDLE: begin
					callCnt_r <= 3'h0;
					if (takeCall) begin
						state_r <= irq_pkg::CALL_RUN;
					end
				end
				irq_pkg::CALL_RUN: begin
					callCnt_r <= callCnt_r + 3'h1;
					if (callLast) begin
						state_r <= irq_pkg::CALL_IDLE;
						callCnt_r <= 3'h0;
					end
				end
				default: begin
					state_r <= irq_pkg::CALL_IDLE;
					callCnt_r <= 3'h0;
				end
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			vector_r <= 16'h0000;
			source_r <= 4'h0;
			callStart_r <= 1'b0;
		end else begin
			callStart_r <= takeCall;
			if (takeCall) begin
				vector_r <= `IRQ_VECTOR_BASE + {9'h000, src_order(reqSrc_r), 3'h0};
				source_r <= reqSrc_r;
			end
		end
	end

	// level committed at vectoring so a stale request cannot slip in
	// nesting of two levels
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			inSvcLow_r <= 1'b0;
			inSvcHigh_r <= 1'b0;
		end else if (takeCall) begin
			if (reqHigh_r) begin
				inSvcHigh_r <= 1'b1;
			end else begin
				inSvcLow_r <= 1'b1;
			end
		end else if (coreStatus.retiDone) begin
			if (inSvcHigh_r) begin
				inSvcHigh_r <= 1'b0;
			end else begin
				inSvcLow_r <= 1'b0;
			end
		end
	end

	// read data valid in the cycle after the strobe only
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			rdData_r <= 8'h00;
		end else if (busReq.rdStrobe) begin
			case (busReq.addr)
				`IRQ_OFS_ENABLE_MAIN: rdData_r <= ieMain_r;
				`IRQ_OFS_PRIORITY_MAIN: rdData_r <= ipMain_r;
				`IRQ_OFS_ENABLE_EXT: rdData_r <= ieExt_r;
				`IRQ_OFS_PRIORITY_EXT: rdData_r <= ipExt_r;
				`IRQ_OFS_PENDING_LO: rdData_r <= pending_r[7:0];
				`IRQ_OFS_PENDING_HI: rdData_r <= {4'h0, pending_r[11:8]};
				`IRQ_OFS_STATUS: begin
					rdData_r <= {source_r, reqValid_r, state_r == irq_pkg::CALL_RUN,
						inSvcHigh_r, inSvcLow_r};
				end
				default: rdData_r <= 8'h00;
			endcase
		end else begin
			rdData_r <= 8'h00;
		end
	end

	assign rdData = rdData_r;

	always_comb begin
		callOut.request = reqValid_r;
		callOut.callStart = callStart_r;
		callOut.calling = state_r == irq_pkg::CALL_RUN;
		callOut.vector = vector_r;
		callOut.source = source_r;
	end

endmodule

// File: bench/two_level_interrupt_handler_monitor.sv
`timescale 1ns/10ps
module two_level_interrupt_handler_monitor (
	// watched ports
	input wire logic clock,
	input wire logic reset_n,
	input wire irq_pkg::bus_req_t busReq,
	input wire logic [7:0] rdData,
	input wire irq_pkg::src_vec_t srcEvent,
	input wire irq_pkg::core_status_t coreStatus,
	input wire irq_pkg::call_out_t callOut
);
	default clocking @(posedge clock); endclocking
	default disable iff (!reset_n);
	// two reserved slots after source 7, one before source 11
	function automatic logic [15:0] vecOf(input logic [3:0] s);
		return 16'h0003 + {9'h000, (s < 4'h8) ? s : (s == 4'hb) ? 4'he : s + 4'h2, 3'h0};
	endfunction
	sequence s_take;
		callOut.request && coreStatus.instrDone && !callOut.calling;
	endsequence
	sequence s_call;
		callOut.calling [*4] ##1 !callOut.calling;
	endsequence
	property p_start;
		s_take |=> callOut.callStart;
	endproperty
	a_start: assert property (p_start) else $error("call not started");
	property p_len;
		callOut.callStart |-> s_call;
	endproperty
	a_len: assert property (p_len) else $error("call length wrong");
	property p_cause;
		callOut.callStart |-> $past(callOut.request) && $past(coreStatus.instrDone);
	endproperty
	a_cause: assert property (p_cause) else $error("call without request");
	property p_return_from_irq_instr;
		coreStatus.retiDone |=> !callOut.callStart;
	endproperty
	a_return_from_irq_instr: assert property (p_return_from_irq_instr) else $error("call right after return");
	property p_vec;
		callOut.callStart |-> callOut.vector == vecOf(callOut.source);
	endproperty
	a_vec: assert property (p_vec) else $error("vector wrong");
	property p_src;
		callOut.callStart |-> callOut.source <= 4'hb;
	endproperty
	a_src: assert property (p_src) else $error("source out of range");
	property p_hold;
		callOut.calling && !callOut.callStart |-> $stable(callOut.vector);
	endproperty
	a_hold: assert property (p_hold) else $error("vector moved in call");
	property p_rst;
		$rose(reset_n) |-> !callOut.calling && !callOut.request && rdData == 8'h00;
	endproperty
	a_rst: assert property (p_rst) else $error("outputs not cleared");
endmodule

bind two_level_interrupt_handler two_level_interrupt_handler_monitor u_mon (.clock(clock), .reset_n(reset_n),
	.busReq(busReq), .rdData(rdData), .srcEvent(srcEvent), .coreStatus(coreStatus), .callOut(callOut));

// File: bench/irq_core_model.sv
`timescale 1ns/10ps
module irq_core_model (
	// clock and reset
	input wire logic clock,
	input wire logic reset_n,
	// bench control
	input wire logic retiReq,
	input wire logic [1:0] instrLen,
	// block side
	input wire irq_pkg::call_out_t callOut,
	output irq_pkg::core_status_t coreStatus
);
	logic [1:0] cnt_r;
	logic retiPend_r;
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			cnt_r <= 2'h0;
			retiPend_r <= 1'b0;
			coreStatus <= '0;
		end else begin
			coreStatus <= '0;
			if (retiReq)
				retiPend_r <= 1'b1;
			// routine ends with return; no instructions retire during a call
			if (!callOut.calling) begin
				if (cnt_r == 2'h0) begin
					cnt_r <= instrLen;
					if (retiPend_r || retiReq) begin
						coreStatus.retiDone <= 1'b1;
						retiPend_r <= 1'b0;
					end else
						coreStatus.instrDone <= 1'b1;
				end else
					cnt_r <= cnt_r - 2'h1;
			end
		end
	end
endmodule

// File: bench/two_level_interrupt_handler_tb.sv
`timescale 1ns/10ps
module two_level_interrupt_handler_tb;
	logic clock;
	logic reset_n;
	irq_pkg::bus_req_t busReq;
	logic [7:0] rdData;
	irq_pkg::src_vec_t srcEvent;
	irq_pkg::core_status_t coreStatus;
	irq_pkg::call_out_t callOut;
	logic retiReq;
	logic [1:0] instrLen;
	logic rdPend;
	logic [7:0] r;
	int fails;
	int comparisons;
	int seed;
	logic [7:0] rdQ[$];
	logic [15:0] vecQ[$];
	logic [7:0] regs[5] = '{8'ha8, 8'hb8, 8'he6, 8'hf6, 8'h80};
	logic [7:0] mask[5] = '{8'hff, 8'h7f, 8'hb9, 8'hb9, 8'h00};

	two_level_interrupt_handler u_two_level_interrupt_handler (.clock(clock), .reset_n(reset_n), .busReq(busReq),
		.rdData(rdData), .srcEvent(srcEvent), .coreStatus(coreStatus), .callOut(callOut));
	irq_core_model u_irq_core_model (.clock(clock), .reset_n(reset_n), .retiReq(retiReq), .instrLen(instrLen),
		.callOut(callOut), .coreStatus(coreStatus));

	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end

	function automatic logic [15:0] vx(input int s);
		return 16'h0003 + 16'(8 * (s < 8 ? s : s == 11 ? 14 : s + 2));
	endfunction

	task check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fails++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task give_verdict;
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// an empty queue turns any unexpected result into a mismatch
	always @(posedge clock) begin
		if (rdPend)
			check("rdData", {8'h00, rdData}, rdQ.size() > 0 ? {8'h00, rdQ.pop_front()} : 16'hffff);
		if (callOut.callStart)
			check("vector", callOut.vector, vecQ.size() > 0 ? vecQ.pop_front() : 16'hffff);
		rdPend <= busReq.rdStrobe;
	end

	task bus(input logic rd, input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		busReq <= '{a, d, ~rd, rd};
		if (rd)
			rdQ.push_back(d);
		@(posedge clock);
		busReq <= '0;
	endtask

	task ev(input irq_pkg::src_vec_t v);
		@(posedge clock);
		srcEvent <= v;
		@(posedge clock);
		srcEvent <= '0;
	endtask

	task call(input logic [15:0] v);
		int n;
		vecQ.push_back(v);
		for (n = 0; vecQ.size() > 0 && n < 100; n++)
			@(posedge clock);
		if (n >= 100) begin
			fails++;
			give_verdict();
		end
		repeat (6) @(posedge clock);
	endtask

	task return_from_irq_instr(input logic idle);
		@(posedge clock);
		retiReq <= 1'b1;
		@(posedge clock);
		retiReq <= 1'b0;
		if (idle)
			repeat (12) @(posedge clock);
	endtask

	initial begin
		seed = 32'h58a6a7cd;
		fails = 0;
		comparisons = 0;
		rdPend = 1'b0;
		reset_n = 1'b0;
		busReq = '0;
		srcEvent = '0;
		retiReq = 1'b0;
		instrLen = 2'h0;
		repeat (3) @(posedge clock);
		reset_n <= 1'b1;
		for (int i = 0; i < 5; i++) begin
			r = 8'($random(seed));
			bus(1, regs[i], 8'h00);
			bus(0, regs[i], r);
			bus(1, regs[i], r & mask[i]);
			bus(0, regs[i], 8'h00);
		end
		$display("test registers done");
		bus(0, 8'ha8, 8'h04);
		ev(12'h004);
		repeat (20) @(posedge clock);
		bus(1, 8'ha7, 8'h04);
		bus(0, 8'ha8, 8'h84);
		call(16'h0013);
		bus(1, 8'ha7, 8'h00);
		return_from_irq_instr(1);
		$display("test global enable done");
		bus(0, 8'ha8, 8'hff);
		bus(0, 8'he6, 8'hb9);
		bus(0, 8'hf6, 8'h08);
		instrLen <= r[1:0];
		ev(12'h020);
		call(16'h002b);
		ev(12'h100);
		call(16'h0053);
		bus(1, 8'haf, 8'h01);
		bus(1, 8'hc9, 8'h83);
		bus(0, 8'haf, 8'h00);
		return_from_irq_instr(1);
		return_from_irq_instr(0);
		call(16'h002b);
		bus(0, 8'ha7, 8'h00);
		return_from_irq_instr(1);
		bus(0, 8'ha7, 8'h30);
		call(16'h0023);
		bus(0, 8'ha7, 8'h20);
		return_from_irq_instr(0);
		call(16'h002b);
		bus(0, 8'ha7, 8'h00);
		return_from_irq_instr(1);
		$display("test priority done");
		bus(0, 8'hf6, 8'h00);
		for (int s = 0; s < 12; s++) begin
			r = 8'($random(seed));
			instrLen <= r[1:0];
			bus(0, s < 8 ? 8'ha7 : 8'haf, 8'h01 << (s % 8));
			call(vx(s));
			bus(0, s < 8 ? 8'ha7 : 8'haf, 8'h00);
			return_from_irq_instr(1);
		end
		$display("test vectors done");
		give_verdict();
	end
endmodule
